// ==== src/cise_dec_if.sv ====
// Interface between the executor and its instruction decoder.
// Assumes the executor drives the word and the decoder answers combinationally.
interface cise_dec_if;
  import cise_pkg::*;
  logic [INSTR_W-1:0] word;
  cise_op_t op;
  logic [FADDR_W-1:0] faddr;
  logic dbit;

  modport decoder (input word, output op, faddr, dbit);
  modport exec (output word, input op, faddr, dbit);
endinterface : cise_dec_if

// ==== src/cise_decoder.sv ====
// Instruction decoder for the executor subset.
// Assumes a full instruction word presented on the interface; purely combinational.
module cise_decoder
  import cise_pkg::*;
(
  // Decode carrier
  cise_dec_if.decoder dif
);

  always_comb
  begin
    dif.faddr = dif.word[FADDR_W-1:0];
    dif.dbit = dif.word[DEST_BIT];
    unique case (dif.word[OPC_MSB:OPC_LSB])
      OPC_WATCHDOG_CLEAR: dif.op = OP_WATCHDOG_CLEAR;
      OPC_CALL_ACC: dif.op = OP_CALL_ACC;
      OPC_COMPLEMENT: dif.op = OP_COMPLEMENT;
      OPC_FILE_CLEAR: dif.op = OP_FILE_CLEAR;
      OPC_DECREMENT: dif.op = OP_DECREMENT;
      OPC_ACC_CLEAR: dif.op = OP_ACC_CLEAR;
      OPC_DEC_SKIP: dif.op = OP_DEC_SKIP;
      // Codes outside the subset run as no-operation
      default: dif.op = OP_NOP;
    endcase
  end

endmodule : cise_decoder

// ==== src/cise_exec.sv ====
// Executor for a subset of an 8-bit core's instructions, reached over APB.
// Assumes one core clock; software issues instructions by writing the INSTR register.
// Behaviour
// - Watchdog clear zeroes the watchdog counter and sets timeout and powerdown flags.
// - Watchdog clear also zeroes the watchdog prescaler in the same instruction.
// - Call through accumulator pushes PC plus one to stack top, flags untouched.
// - Then PC low byte takes accumulator, PC high bits take latch bits 6..0.
// - Call through accumulator takes two instruction cycles.
// - Complement writes inverted file value to destination and updates zero flag.
// - Destination bit 0 selects accumulator, 1 writes back to the file register.
// - File clear writes zero to the file register and sets the zero flag.
// - Decrement writes file value minus one to destination and updates zero flag.
// - Accumulator clear zeroes the accumulator and sets the zero flag.
// - Decrement-and-skip writes file minus one to destination, flags unchanged.
// - A zero result discards the next instruction as a no-op, two cycles.
//
// Our own choices: the placing of the registers and the APB slave port.
module cise_exec
  import cise_pkg::*;
#(
  parameter int WD_PRE_W = 8
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  function automatic logic [PC_W-1:0] pc_inc(input logic [PC_W-1:0] pc);
    pc_inc = pc + PC_STEP;
  endfunction : pc_inc

  cise_dec_if dif ();
  cise_decoder u_dec (.dif(dif));

  logic [DATA_W-1:0] file_mem [FILE_DEPTH];
  logic [DATA_W-1:0] acc_r;
  logic [LATCH_W-1:0] pc_high_latch_r;
  logic [PC_W-1:0] pc_r;
  logic [PC_W-1:0] return_stack_top_r;
  logic [DATA_W-1:0] watchdog_counter_r;
  logic [WD_PRE_W-1:0] wd_prescaler_r;
  logic timeout_flag_n_r;
  logic powerdown_flag_n_r;
  logic zero_r;
  logic skip_pending_r;
  logic [FADDR_W-1:0] faddr_r;
  logic [INSTR_W-1:0] last_instr_r;
  logic [CYC_W-1:0] cycles_r;
  cise_state_t state_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;

  logic wr_take;
  logic issue;
  logic exec;
  logic discard;
  logic stall;
  logic ready_nxt;
  logic mapped;
  logic [31:0] rd_mux;
  logic [DATA_W-1:0] file_rd;
  logic [DATA_W-1:0] result;
  logic to_acc;
  logic to_file;
  logic wd_pre_wrap;

  assign dif.word = pwdata[INSTR_W-1:0];
  assign file_rd = file_mem[dif.faddr];
  assign wr_take = psel & penable & pready_r & pwrite;
  assign issue = wr_take & (paddr == OFS_INSTR);
  assign exec = issue & ~skip_pending_r;
  assign discard = issue & skip_pending_r;
  // A new instruction waits out the second cycle of a two-cycle call
  assign stall = pwrite & (paddr == OFS_INSTR) & (state_r != EX_IDLE);
  assign ready_nxt = psel & ~pready_r & ~stall;
  assign wd_pre_wrap = &wd_prescaler_r;

  // Result and destination
  always_comb
  begin
    result = RST_DATA;
    to_acc = 1'b0;
    to_file = 1'b0;
    unique case (dif.op)
      OP_COMPLEMENT:
      begin
        result = ~file_rd;
        to_acc = ~dif.dbit;
        to_file = dif.dbit;
      end
      OP_DECREMENT, OP_DEC_SKIP:
      begin
        result = file_rd - DATA_ONE;
        to_acc = ~dif.dbit;
        to_file = dif.dbit;
      end
      OP_FILE_CLEAR:
        to_file = 1'b1;
      OP_ACC_CLEAR:
        to_acc = 1'b1;
      OP_NOP, OP_WATCHDOG_CLEAR, OP_CALL_ACC:
        result = RST_DATA;
    endcase
  end

  // Register read decode
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    mapped = 1'b1;
    unique case (paddr)
      OFS_INSTR: rd_mux[INSTR_W-1:0] = last_instr_r;
      OFS_ACC: rd_mux[DATA_W-1:0] = acc_r;
      OFS_LATCH: rd_mux[LATCH_W-1:0] = pc_high_latch_r;
      OFS_STATUS:
      begin
        rd_mux[ST_ZERO_BIT] = zero_r;
        rd_mux[ST_POWERDOWN_BIT] = powerdown_flag_n_r;
        rd_mux[ST_TIMEOUT_BIT] = timeout_flag_n_r;
        rd_mux[ST_SKIP_BIT] = skip_pending_r;
        rd_mux[ST_BUSY_BIT] = (state_r != EX_IDLE);
      end
      OFS_PC: rd_mux[PC_W-1:0] = pc_r;
      OFS_STACK: rd_mux[PC_W-1:0] = return_stack_top_r;
      OFS_WATCHDOG:
      begin
        rd_mux[DATA_W-1:0] = watchdog_counter_r;
        rd_mux[WD_PRE_LSB +: WD_PRE_W] = wd_prescaler_r;
      end
      OFS_FADDR: rd_mux[FADDR_W-1:0] = faddr_r;
      OFS_FDATA: rd_mux[DATA_W-1:0] = file_mem[faddr_r];
      OFS_CYCLES: rd_mux[CYC_W-1:0] = cycles_r;
      default: mapped = 1'b0;
    endcase
  end

  // APB answer, zero wait states unless stalled
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pready_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end
    else
    begin
      pready_r <= ready_nxt;
      prdata_r <= (ready_nxt & ~pwrite) ? rd_mux : 32'h0000_0000;
      pslverr_r <= ready_nxt & ~mapped;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;

  // Sequencing: two-cycle call and skip of the next instruction
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_r <= EX_IDLE;
      skip_pending_r <= 1'b0;
      cycles_r <= RST_CYC;
      last_instr_r <= '0;
    end
    else
    begin
      unique case (state_r)
        EX_IDLE: state_r <= (exec && dif.op == OP_CALL_ACC) ? EX_SECOND : EX_IDLE;
        EX_SECOND: state_r <= EX_IDLE;
      endcase
      if (issue)
      begin
        last_instr_r <= dif.word;
        skip_pending_r <= exec && dif.op == OP_DEC_SKIP && result == RST_DATA;
      end
      if (issue || state_r == EX_SECOND)
        cycles_r <= cycles_r + 16'h0001;
    end
  end

  // Program counter and return stack top
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pc_r <= RST_PC;
      return_stack_top_r <= RST_PC;
    end
    else if (exec && dif.op == OP_CALL_ACC)
    begin
      return_stack_top_r <= pc_inc(pc_r);
      pc_r <= {pc_high_latch_r, acc_r};
    end
    else if (issue)
      pc_r <= pc_inc(pc_r);
  end

  // Accumulator, latch and zero flag
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      acc_r <= RST_DATA;
      pc_high_latch_r <= '0;
      zero_r <= 1'b0;
    end
    else if (exec)
    begin
      if (to_acc)
        acc_r <= result;
      if (dif.op == OP_COMPLEMENT || dif.op == OP_DECREMENT)
        zero_r <= (result == RST_DATA);
      else if (dif.op == OP_FILE_CLEAR || dif.op == OP_ACC_CLEAR)
        zero_r <= 1'b1;
    end
    else if (wr_take)
    begin
      if (paddr == OFS_ACC)
        acc_r <= pwdata[DATA_W-1:0];
      if (paddr == OFS_LATCH)
        pc_high_latch_r <= pwdata[LATCH_W-1:0];
      if (paddr == OFS_STATUS)
        zero_r <= pwdata[ST_ZERO_BIT];
    end
  end

  // File registers; array holds no reset so it maps onto plain storage
  always_ff @(posedge core_clk)
  begin
    if (exec && to_file)
      file_mem[dif.faddr] <= result;
    else if (wr_take && paddr == OFS_FDATA)
      file_mem[faddr_r] <= pwdata[DATA_W-1:0];
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      faddr_r <= '0;
    else if (wr_take && paddr == OFS_FADDR)
      faddr_r <= pwdata[FADDR_W-1:0];
  end

  // Watchdog counter and prescaler; the clear wins over counting
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wd_prescaler_r <= '0;
      watchdog_counter_r <= RST_DATA;
      timeout_flag_n_r <= 1'b1;
      powerdown_flag_n_r <= 1'b1;
    end
    else if (exec && dif.op == OP_WATCHDOG_CLEAR)
    begin
      wd_prescaler_r <= '0;
      watchdog_counter_r <= RST_DATA;
      timeout_flag_n_r <= 1'b1;
      powerdown_flag_n_r <= 1'b1;
    end
    else
    begin
      wd_prescaler_r <= wd_prescaler_r + 1'b1;
      if (wd_pre_wrap)
        watchdog_counter_r <= watchdog_counter_r + DATA_ONE;
      if (wd_pre_wrap && &watchdog_counter_r)
        timeout_flag_n_r <= 1'b0;
      if (wr_take && paddr == OFS_STATUS)
        powerdown_flag_n_r <= pwdata[ST_POWERDOWN_BIT];
    end
  end

  a_wd_clear_flags: assert property (@(posedge core_clk) disable iff (!rstn)
    exec && dif.op == OP_WATCHDOG_CLEAR |=>
      watchdog_counter_r == RST_DATA && timeout_flag_n_r && powerdown_flag_n_r)
    else $error("watchdog clear left counter or flags wrong");

  a_wd_clear_prescaler: assert property (@(posedge core_clk) disable iff (!rstn)
    exec && dif.op == OP_WATCHDOG_CLEAR |=> wd_prescaler_r == '0 ##1 wd_prescaler_r == 1)
    else $error("watchdog prescaler not restarted");

  a_call_push: assert property (@(posedge core_clk) disable iff (!rstn)
    exec && dif.op == OP_CALL_ACC |=>
      return_stack_top_r == $past(pc_r) + PC_STEP && $stable(zero_r))
    else $error("call pushed wrong return address or touched flags");

  a_call_target: assert property (@(posedge core_clk) disable iff (!rstn)
    exec && dif.op == OP_CALL_ACC |=> pc_r == {$past(pc_high_latch_r), $past(acc_r)})
    else $error("call loaded wrong target");

  a_call_two_cycles: assert property (@(posedge core_clk) disable iff (!rstn)
    exec && dif.op == OP_CALL_ACC |=>
      state_r == EX_SECOND ##1 state_r == EX_IDLE && cycles_r == $past(cycles_r, 2) + 16'h0002)
    else $error("call did not take two cycles");

  a_comp_result: assert property (@(posedge core_clk) disable iff (!rstn)
    exec && dif.op == OP_COMPLEMENT && !dif.dbit |=>
      acc_r == ~$past(file_rd) && zero_r == (acc_r == RST_DATA))
    else $error("complement result or zero flag wrong");

  a_dest_file: assert property (@(posedge core_clk) disable iff (!rstn)
    exec && dif.dbit && (dif.op == OP_COMPLEMENT || dif.op == OP_DECREMENT) |=>
      $stable(acc_r) && file_mem[$past(dif.faddr)] == $past(result))
    else $error("file destination not honoured");

  a_file_clear: assert property (@(posedge core_clk) disable iff (!rstn)
    exec && dif.op == OP_FILE_CLEAR |=> zero_r && file_mem[$past(dif.faddr)] == RST_DATA)
    else $error("file clear failed");

  a_dec_result: assert property (@(posedge core_clk) disable iff (!rstn)
    exec && dif.op == OP_DECREMENT && !dif.dbit |=>
      acc_r == $past(file_rd) - DATA_ONE && zero_r == ($past(file_rd) == DATA_ONE))
    else $error("decrement result or zero flag wrong");

  a_acc_clear: assert property (@(posedge core_clk) disable iff (!rstn)
    exec && dif.op == OP_ACC_CLEAR |=> acc_r == RST_DATA && zero_r)
    else $error("accumulator clear failed");

  a_skip_flags: assert property (@(posedge core_clk) disable iff (!rstn)
    exec && dif.op == OP_DEC_SKIP |=> $stable(zero_r) && $stable(timeout_flag_n_r))
    else $error("decrement-and-skip changed a flag");

  a_skip_discard: assert property (@(posedge core_clk) disable iff (!rstn)
    discard |=> $stable(acc_r) && !skip_pending_r && pc_r == $past(pc_r) + PC_STEP)
    else $error("skipped instruction was not discarded");

  a_skip_arm: assert property (@(posedge core_clk) disable iff (!rstn)
    exec && dif.op == OP_DEC_SKIP |=> skip_pending_r == ($past(file_rd) == DATA_ONE))
    else $error("skip armed on wrong result");

  a_decode_fields: assert property (@(posedge core_clk) disable iff (!rstn)
    issue |-> dif.faddr == pwdata[FADDR_W-1:0] && dif.dbit == pwdata[DEST_BIT])
    else $error("decoded address or destination wrong");

  a_single_cycle: assert property (@(posedge core_clk) disable iff (!rstn)
    exec && dif.op != OP_CALL_ACC |=> state_r == EX_IDLE)
    else $error("single-cycle instruction held the executor");

endmodule : cise_exec

// ==== src/cise_pkg.sv ====
// Package for the instruction subset executor: opcodes, field layout,
// register map and reset values.
// Assumes a single core clock domain and an APB register port.
package cise_pkg;

  // Instruction word layout
  localparam int INSTR_W = 14;
  localparam int OPC_MSB = 13;
  localparam int OPC_LSB = 8;
  localparam int DEST_BIT = 7;
  localparam int FADDR_W = 7;
  localparam int OPC_W = OPC_MSB - OPC_LSB + 1;

  // Opcode field values
  localparam logic [OPC_W-1:0] OPC_WATCHDOG_CLEAR = 6'h01;
  localparam logic [OPC_W-1:0] OPC_CALL_ACC = 6'h02;
  localparam logic [OPC_W-1:0] OPC_FILE_CLEAR = 6'h03;
  localparam logic [OPC_W-1:0] OPC_DECREMENT = 6'h04;
  localparam logic [OPC_W-1:0] OPC_ACC_CLEAR = 6'h05;
  localparam logic [OPC_W-1:0] OPC_COMPLEMENT = 6'h09;
  localparam logic [OPC_W-1:0] OPC_DEC_SKIP = 6'h0b;

  // Datapath widths
  localparam int DATA_W = 8;
  localparam int PC_W = 15;
  localparam int LATCH_W = 7;
  localparam int CYC_W = 16;
  localparam int FILE_DEPTH = 128;

  // Register byte offsets
  localparam logic [7:0] OFS_INSTR = 8'h00;
  localparam logic [7:0] OFS_ACC = 8'h04;
  localparam logic [7:0] OFS_LATCH = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_PC = 8'h10;
  localparam logic [7:0] OFS_STACK = 8'h14;
  localparam logic [7:0] OFS_WATCHDOG = 8'h18;
  localparam logic [7:0] OFS_FADDR = 8'h1c;
  localparam logic [7:0] OFS_FDATA = 8'h20;
  localparam logic [7:0] OFS_CYCLES = 8'h24;

  // Status register bit positions
  localparam int ST_ZERO_BIT = 0;
  localparam int ST_POWERDOWN_BIT = 1;
  localparam int ST_TIMEOUT_BIT = 2;
  localparam int ST_SKIP_BIT = 3;
  localparam int ST_BUSY_BIT = 4;

  // Watchdog read field layout
  localparam int WD_PRE_LSB = 8;

  // Reset values and step constants
  localparam logic [DATA_W-1:0] RST_DATA = 8'h00;
  localparam logic [PC_W-1:0] RST_PC = 15'h0000;
  localparam logic [CYC_W-1:0] RST_CYC = 16'h0000;
  localparam logic [PC_W-1:0] PC_STEP = 15'h0001;
  localparam logic [DATA_W-1:0] DATA_ONE = 8'h01;

  typedef enum logic [2:0]
  {
    OP_NOP,
    OP_WATCHDOG_CLEAR,
    OP_CALL_ACC,
    OP_COMPLEMENT,
    OP_FILE_CLEAR,
    OP_DECREMENT,
    OP_ACC_CLEAR,
    OP_DEC_SKIP
  } cise_op_t;

  typedef enum logic
  {
    EX_IDLE,
    EX_SECOND
  } cise_state_t;

endpackage : cise_pkg

// ==== tb/cise_exec_tb.sv ====
// Self-checking bench for the instruction subset executor.
// Assumes the executor answers every APB transfer with a one-cycle pready pulse.
module cise_exec_tb
  import cise_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [31:0] q;
  logic [31:0] p;
  logic [31:0] c;
  logic e;
  int fail_count = 0;
  int checks = 0;

  // Short prescaler keeps the watchdog timeout near a thousand cycles
  cise_exec #(.WD_PRE_W(2)) i_cise_exec (
    .core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  initial
  begin
    forever #2 core_clk = ~core_clk;
  end

  task close_out;
    $display("mismatches %0d, comparisons %0d", fail_count, checks);
    if (fail_count == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : close_out

  task check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // Idle edge first, so two transfers never drive psel in one time step
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // No wait limit here: only the watchdog process ends a hung transfer
    do
    begin
      @(posedge core_clk);
    end
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(q, exp);
  endtask : rd

  task set_file(input logic [6:0] a, input logic [7:0] v);
    wr(OFS_FADDR, {25'h0, a});
    wr(OFS_FDATA, {24'h0, v});
  endtask : set_file

  task op(input logic [OPC_W-1:0] o, input logic d, input logic [6:0] f);
    wr(OFS_INSTR, {18'h0, o, d, f});
  endtask : op

  task t_complement;
    set_file(7'h7f, 8'h3c);
    wr(OFS_STATUS, 32'h3);
    op(OPC_COMPLEMENT, 1'b0, 7'h7f);
    rd(OFS_ACC, 32'hc3);
    rd(OFS_FDATA, 32'h3c);
    rd(OFS_STATUS, 32'h6);
    set_file(7'h00, 8'hff);
    op(OPC_COMPLEMENT, 1'b1, 7'h00);
    rd(OFS_FDATA, 32'h0);
    rd(OFS_ACC, 32'hc3);
    rd(OFS_STATUS, 32'h7);
  endtask : t_complement

  task t_clear;
    apb(1'b0, OFS_PC, 32'h0);
    p = q;
    apb(1'b0, OFS_CYCLES, 32'h0);
    c = q;
    set_file(7'h40, 8'h99);
    wr(OFS_STATUS, 32'h2);
    op(OPC_FILE_CLEAR, 1'b1, 7'h40);
    rd(OFS_FDATA, 32'h0);
    rd(OFS_STATUS, 32'h7);
    wr(OFS_ACC, 32'h77);
    wr(OFS_STATUS, 32'h2);
    op(OPC_ACC_CLEAR, 1'b0, 7'h00);
    rd(OFS_ACC, 32'h0);
    rd(OFS_STATUS, 32'h7);
    rd(OFS_CYCLES, c + 32'h2);
    rd(OFS_PC, p + 32'h2);
  endtask : t_clear

  // Bitwise-complementary addresses catch a swapped or dropped address bit
  task t_decrement;
    set_file(7'h55, 8'h11);
    set_file(7'h2a, 8'h01);
    wr(OFS_STATUS, 32'h2);
    op(OPC_DECREMENT, 1'b1, 7'h2a);
    rd(OFS_FDATA, 32'h0);
    rd(OFS_STATUS, 32'h7);
    op(OPC_DECREMENT, 1'b0, 7'h55);
    rd(OFS_ACC, 32'h10);
    rd(OFS_STATUS, 32'h6);
    wr(OFS_FADDR, 32'h55);
    rd(OFS_FDATA, 32'h11);
    op(OPC_DECREMENT, 1'b0, 7'h2a);
    rd(OFS_ACC, 32'hff);
  endtask : t_decrement

  task t_skip;
    set_file(7'h10, 8'h01);
    wr(OFS_STATUS, 32'h2);
    wr(OFS_ACC, 32'h33);
    apb(1'b0, OFS_PC, 32'h0);
    p = q;
    op(OPC_DEC_SKIP, 1'b1, 7'h10);
    rd(OFS_FDATA, 32'h0);
    rd(OFS_STATUS, 32'he);
    op(OPC_ACC_CLEAR, 1'b0, 7'h00);
    rd(OFS_ACC, 32'h33);
    rd(OFS_STATUS, 32'h6);
    rd(OFS_PC, p + 32'h2);
    set_file(7'h10, 8'h05);
    wr(OFS_STATUS, 32'h3);
    op(OPC_DEC_SKIP, 1'b0, 7'h10);
    rd(OFS_ACC, 32'h04);
    rd(OFS_STATUS, 32'h7);
    rd(OFS_FDATA, 32'h05);
    op(OPC_ACC_CLEAR, 1'b0, 7'h00);
    rd(OFS_ACC, 32'h0);
  endtask : t_skip

  task t_call;
    wr(OFS_ACC, 32'ha5);
    wr(OFS_LATCH, 32'h5b);
    wr(OFS_STATUS, 32'h3);
    apb(1'b0, OFS_PC, 32'h0);
    p = q;
    apb(1'b0, OFS_CYCLES, 32'h0);
    c = q;
    op(OPC_CALL_ACC, 1'b0, 7'h00);
    rd(OFS_STACK, p + 32'h1);
    rd(OFS_PC, {17'h0, 7'h5b, 8'ha5});
    rd(OFS_STATUS, 32'h7);
    rd(OFS_CYCLES, c + 32'h2);
    rd(OFS_INSTR, {18'h0, OPC_CALL_ACC, 8'h00});
  endtask : t_call

  // Call, then the next setup at once: it must wait out the busy cycle
  task t_call_busy;
    int n;
    n = 0;
    wr(OFS_STATUS, 32'h2);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= 1'b1;
    paddr <= OFS_INSTR;
    pwdata <= {18'h0, OPC_CALL_ACC, 8'h00};
    @(posedge core_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge core_clk);
    end
    while (pready !== 1'b1);
    penable <= 1'b0;
    pwdata <= {18'h0, OPC_ACC_CLEAR, 8'h00};
    @(posedge core_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    check(n, 32'h2);
    rd(OFS_ACC, 32'h0);
    rd(OFS_STATUS, 32'h7);
  endtask : t_call_busy

  task t_watchdog;
    int n;
    n = 0;
    wr(OFS_STATUS, 32'h0);
    do
    begin
      apb(1'b0, OFS_STATUS, 32'h0);
      n++;
    end
    while (q[ST_TIMEOUT_BIT] !== 1'b0 && n < 800);
    check(q, 32'h0);
    op(OPC_WATCHDOG_CLEAR, 1'b0, 7'h00);
    apb(1'b0, OFS_WATCHDOG, 32'h0);
    check({24'h0, q[7:0]}, 32'h0);
    check({30'h0, q[WD_PRE_LSB +: 2]}, 32'h1);
    rd(OFS_STATUS, 32'h6);
  endtask : t_watchdog

  task t_refuse;
    apb(1'b0, 8'h30, 32'h0);
    check({31'h0, e}, 32'h1);
    check(q, 32'h0);
    apb(1'b0, OFS_PC, 32'h0);
    p = q;
    wr(OFS_PC, 32'h1234);
    rd(OFS_PC, p);
    // Opcode outside the subset runs as a no-operation
    op(6'h3f, 1'b1, 7'h00);
    rd(OFS_PC, p + 32'h1);
  endtask : t_refuse

  // Second reset in mid-run must bring back the same state as power-up
  task t_reset;
    wr(OFS_ACC, 32'h5a);
    @(posedge core_clk);
    rstn <= 1'b0;
    repeat (5) @(posedge core_clk);
    rstn <= 1'b1;
    rd(OFS_ACC, 32'h0);
    rd(OFS_PC, 32'h0);
    rd(OFS_STACK, 32'h0);
    rd(OFS_STATUS, 32'h6);
    rd(OFS_CYCLES, 32'h0);
  endtask : t_reset

  initial
  begin
    #100000;
    fail_count++;
    close_out();
  end

  initial
  begin
    repeat (5) @(posedge core_clk);
    rstn <= 1'b1;
    rd(OFS_STATUS, 32'h6);
    rd(OFS_PC, 32'h0);
    t_complement();
    t_clear();
    t_decrement();
    t_skip();
    t_call();
    t_call_busy();
    t_watchdog();
    t_refuse();
    t_reset();
    close_out();
  end
endmodule : cise_exec_tb
